// File: design/ctw_core.sv
// control timer waveform core: counter, channels, waveform extensions
// assumes apb master on sys_clk; events and fault pins are asynchronous
//
// Notes on behaviour
// - debug halt stops counting unless run bit
// - guard never blocks period, channel, pattern writes
// - debug halt or debugger access lifts guard
// - async inputs pass a synchroniser first, except the unfiltered counter fault path
// - ceiling from period or channel zero
// - detect counter floor and all-ones maximum
// - update at ceiling or floor per direction
// - four channels, compare or capture
// - counter and value registers 24 bits
// - each shadow has a valid flag
// - ceiling/floor raise interrupt, dma, event
// - count clock ticks or events; events capture
// - recoverable fault restarts, halts or masks
// - counter events shared with non-recoverable fault
// - recoverable fault filtered, blanked, windowed
// - routing matrix selects output distribution
// - dead time splits into non-overlapping sides
// - swap exchanges low and high side
// - pattern levels change on update or on a direct pattern write
// - non-recoverable fault forces safe values
// - unfiltered counter fault acts asynchronously
// - requests and events usable while sleeping
`include "ctw_consts.svh"
module ctw_core
  import ctw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpuHalted,
  input  wire logic        debuggerAccess,
  input  wire logic        guardEnable,
  input  wire logic        channelEventInA,
  input  wire logic        channelEventInB,
  input  wire logic        counterEventInA,
  input  wire logic        counterEventInB,
  input  wire logic [3:0]  captureEventIn,
  output logic             irqReq,
  output logic             dmaReq,
  output logic             overflowEvent,
  output logic [7:0]       wavePins
);
  localparam int CW = `CTW_CNT_W;
  localparam int NC = `CTW_NCH;

  // software state
  logic          enable_q, dirDown_q, oneShot_q, evCount_q, dbgRun_q;
  logic          filtOn_q, stopped_q;
  ctw_wavegen_t  waveGen_q;
  ctw_rfault_t   rfAct_q;
  logic [1:0]    output_routing_matrix_q;
  logic [3:0]    cptEn_q, swap_q, dtEn_q;
  logic [7:0]    polInv_q, nrEn_q, nrVal_q, pattEn_q, pattVal_q;
  logic [7:0]    pattShEn_q, pattShVal_q, dtLs_q, dtHs_q, blank_q;
  logic [CW-1:0] count_q, per_q, perSh_q;
  logic [CW-1:0] ch_q [NC];
  logic [CW-1:0] chSh_q [NC];
  logic          perShV_q, pattShV_q;
  logic [NC-1:0] chShV_q, capFlag_q;
  logic          ovfFlag_q, nrFlag_q, rfFlag_q;

  // three-stage synchronisers for every asynchronous input
  localparam int NS = 8;
  logic [NS-1:0] asyncIn, s1_q, s2_q, s3_q, sIn;
  assign asyncIn = {captureEventIn, counterEventInB, counterEventInA,
                    channelEventInB, channelEventInA};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sIn  <= '0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NS; i++) begin
        if (s2_q[i] == s3_q[i]) sIn[i] <= s3_q[i];
      end
    end
  end
  logic rfIn, countEv, retrigEv, nrRaw, nrSync, nrForce;
  logic [3:0] capEv;
  logic [3:0] capPrev_q;
  assign rfIn     = sIn[0] | sIn[1];
  assign countEv  = sIn[2];
  assign retrigEv = sIn[3];
  assign capEv    = sIn[7:4] & ~capPrev_q;

  // apb slave, zero wait state; guard covers ctrl, dbg, drv, flt and count registers
  logic        wrEn, rdEn, guardBlock, protReg;
  logic [11:0] addr;
  assign addr   = {paddr[11:2], 2'b00};
  assign wrEn   = psel & penable & pwrite;
  assign rdEn   = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign protReg = (addr == `CTW_OFF_CTRL) || (addr == `CTW_OFF_DBG) ||
                   (addr == `CTW_OFF_DRV)  || (addr == `CTW_OFF_FLT) ||
                   (addr == `CTW_OFF_COUNT);
  assign guardBlock = guardEnable & protReg & ~cpuHalted
                      & ~debuggerAccess;
  logic mapped;
  assign mapped = (addr <= `CTW_OFF_PATTSH) ||
                  (addr >= `CTW_OFF_CH && addr < `CTW_OFF_CHSH + 12'h010);
  assign pslverr = psel & penable & (~mapped | (pwrite & guardBlock));
  logic wr;
  assign wr = wrEn & mapped & ~guardBlock;
  logic [1:0] chIdx;
  assign chIdx = addr[3:2];

  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {enable_q, dirDown_q, oneShot_q, evCount_q, filtOn_q} <= '0;
      cptEn_q <= '0;
      dbgRun_q <= 1'b0;
      waveGen_q <= CTW_WG_NFRQ;
      output_routing_matrix_q <= '0;
      swap_q <= '0;
      dtEn_q <= '0;
      polInv_q <= '0;
      nrEn_q <= '0;
      nrVal_q <= '0;
      rfAct_q <= CTW_RF_OFF;
      blank_q <= '0;
      dtLs_q <= `CTW_DT_RST;
      dtHs_q <= `CTW_DT_RST;
    end else if (wr) begin
      unique case (addr)
        `CTW_OFF_CTRL: {filtOn_q, cptEn_q, evCount_q, oneShot_q,
                        dirDown_q, enable_q} <= pwdata[8:0];
        `CTW_OFF_DBG:  dbgRun_q <= pwdata[0];
        `CTW_OFF_WAVE: begin
          waveGen_q <= ctw_wavegen_t'(pwdata[2:0]);
          output_routing_matrix_q    <= pwdata[5:4];
          swap_q    <= pwdata[11:8];
          dtEn_q    <= pwdata[15:12];
          dtLs_q    <= pwdata[23:16];
          dtHs_q    <= pwdata[31:24];
        end
        `CTW_OFF_DRV: {polInv_q, nrVal_q, nrEn_q} <= pwdata[23:0];
        `CTW_OFF_FLT: begin
          blank_q <= pwdata[15:8];
          rfAct_q <= ctw_rfault_t'(pwdata[1:0]);
        end
        default: ;
      endcase
    end
  end

  // ceiling select and limit detection
  logic [CW-1:0] top;
  logic atZero, atMax, atTop, update, tick, run, rfRestart, rfHalt;
  assign top = (waveGen_q == CTW_WG_MFRQ || waveGen_q == CTW_WG_MPWM)
               ? ch_q[0] : per_q;
  assign atZero = (count_q == '0);
  assign atMax  = (count_q == '1);
  assign atTop  = (count_q >= top);
  assign run    = enable_q & ~stopped_q & (~cpuHalted | dbgRun_q);
  assign tick   = run & ~rfHalt & (evCount_q ? countEv : 1'b1);
  assign update = tick & (dirDown_q ? atZero : atTop);

  // recoverable fault: filter, blanking window after update, then action
  logic [2:0] filtCnt_q;
  logic [7:0] blankCnt_q;
  logic       rfQual_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filtCnt_q  <= '0;
      blankCnt_q <= '0;
      rfQual_q   <= 1'b0;
    end else begin
      if (update) blankCnt_q <= blank_q;
      else if (blankCnt_q != '0) blankCnt_q <= blankCnt_q - 8'h01;
      if (!rfIn) filtCnt_q <= '0;
      else if (filtCnt_q != `CTW_FILT_LEN) filtCnt_q <= filtCnt_q + 3'h1;
      rfQual_q <= rfIn & (blankCnt_q == '0)
                  & (!filtOn_q | filtCnt_q == `CTW_FILT_LEN);
    end
  end
  assign rfRestart = rfQual_q & (rfAct_q == CTW_RF_RESTART);
  assign rfHalt    = rfQual_q & (rfAct_q == CTW_RF_HALT);

  // counter; a software write wins over counting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= '0;
      stopped_q <= 1'b0;
    end else if (wr && addr == `CTW_OFF_COUNT) begin
      count_q <= pwdata[CW-1:0];
    end else if (!enable_q) begin
      stopped_q <= 1'b0;
    end else if (rfRestart || (retrigEv && !evCount_q)) begin
      count_q   <= dirDown_q ? top : '0;
      stopped_q <= 1'b0;
    end else if (tick) begin
      if (update) begin
        count_q   <= dirDown_q ? top : '0;
        stopped_q <= oneShot_q;
      end else begin
        count_q <= dirDown_q ? count_q - 1'b1 : count_q + 1'b1;
      end
    end
  end

  // value registers, shadows and valid flags; set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q <= `CTW_PER_RST;
      perSh_q <= `CTW_PER_RST;
      perShV_q <= 1'b0;
      pattEn_q <= '0;
      pattVal_q <= '0;
      pattShEn_q <= '0;
      pattShVal_q <= '0;
      pattShV_q <= 1'b0;
      chShV_q <= '0;
      capFlag_q <= '0;
      capPrev_q <= '0;
      for (int i = 0; i < NC; i++) begin
        ch_q[i] <= '0;
        chSh_q[i] <= '0;
      end
    end else begin
      capPrev_q <= sIn[7:4];
      if (update && perShV_q) begin
        per_q <= perSh_q;
        perShV_q <= 1'b0;
      end
      if (update && pattShV_q) begin
        {pattEn_q, pattVal_q} <= {pattShEn_q, pattShVal_q};
        pattShV_q <= 1'b0;
      end
      for (int i = 0; i < NC; i++) begin
        if (cptEn_q[i] && capEv[i]) begin
          ch_q[i] <= count_q;
          capFlag_q[i] <= 1'b1;
        end else if (update && chShV_q[i] && !cptEn_q[i]) begin
          ch_q[i] <= chSh_q[i];
          chShV_q[i] <= 1'b0;
        end
      end
      if (wr) begin
        if (addr == `CTW_OFF_PER) per_q <= pwdata[CW-1:0];
        if (addr == `CTW_OFF_PERSH) begin
          perSh_q <= pwdata[CW-1:0];
          perShV_q <= 1'b1;
        end
        if (addr == `CTW_OFF_PATTERN_VALUE) {pattEn_q, pattVal_q} <= pwdata[15:0];
        if (addr == `CTW_OFF_PATTSH) begin
          {pattShEn_q, pattShVal_q} <= pwdata[15:0];
          pattShV_q <= 1'b1;
        end
        if (addr[11:4] == `CTW_OFF_CH >> 4) begin
          ch_q[chIdx] <= pwdata[CW-1:0];
        end
        if (addr[11:4] == `CTW_OFF_CHSH >> 4) begin
          chSh_q[chIdx] <= pwdata[CW-1:0];
          chShV_q[chIdx] <= 1'b1;
        end
        if (addr == `CTW_OFF_FLAGS) begin
          capFlag_q <= (capFlag_q & ~pwdata[7:4]) | (capEv & cptEn_q);
        end
      end
    end
  end

  // sticky flags: write one to clear, a new event wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag_q <= 1'b0;
      nrFlag_q  <= 1'b0;
      rfFlag_q  <= 1'b0;
    end else begin
      if (wr && addr == `CTW_OFF_FLAGS) begin
        ovfFlag_q <= ovfFlag_q & ~pwdata[0];
        nrFlag_q  <= nrFlag_q & ~pwdata[1];
        rfFlag_q  <= rfFlag_q & ~pwdata[2];
      end
      if (update) ovfFlag_q <= 1'b1;
      if (nrSync) nrFlag_q <= 1'b1;
      if (rfQual_q) rfFlag_q <= 1'b1;
    end
  end

  // request lines stay combinational so they work with bus clock gated
  assign irqReq = ovfFlag_q | nrFlag_q | rfFlag_q | (|capFlag_q);
  assign dmaReq = ovfFlag_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) overflowEvent <= 1'b0;
    else overflowEvent <= update;
  end

  // compare waveforms, then recoverable mask
  logic [NC-1:0] cmpWave;
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      cmpWave[i] = (count_q < ch_q[i]) & ~cptEn_q[i]
                   & ~(rfQual_q & rfAct_q == CTW_RF_MASK);
    end
  end

  // routing matrix onto eight outputs
  logic [7:0] routed;
  always_comb begin
    unique case (output_routing_matrix_q)
      2'h0: routed = {cmpWave, cmpWave};
      2'h1: routed = {cmpWave[1:0], cmpWave[1:0], cmpWave[1:0],
                      cmpWave[1:0]};
      2'h2: routed = {8{cmpWave[0]}};
      2'h3: routed = {{4{cmpWave[1]}}, cmpWave[0], cmpWave[0],
                      cmpWave[0], cmpWave[0]};
    endcase
  end

  // dead-time pairs on the four lowest routed outputs
  logic [3:0] ls, hs;
  for (genvar g = 0; g < 4; g++) begin : g_dti
    ctw_dead_time u_dti (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .enable   (dtEn_q[g]),
      .wave     (routed[g]),
      .deadLs   (dtLs_q),
      .deadHs   (dtHs_q),
      .lowSide  (ls[g]),
      .highSide (hs[g])
    );
  end

  // swap, pattern, polarity; the fault force sits last before the pins
  logic [7:0] swapped, patterned, preFault;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      swapped[i]     = swap_q[i] ? hs[i] : ls[i];
      swapped[i + 4] = swap_q[i] ? ls[i] : hs[i];
    end
    for (int i = 0; i < 8; i++) begin
      patterned[i] = pattEn_q[i] ? pattVal_q[i] : swapped[i];
    end
    preFault = patterned ^ polInv_q;
  end

  // unfiltered faults bypass the clock entirely
  assign nrRaw   = counterEventInA | counterEventInB;
  assign nrSync  = sIn[2] | sIn[3];
  assign nrForce = (filtOn_q ? nrSync : nrRaw) | stopped_q;
  logic [7:0] pinOut_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pinOut_q <= '0;
    else pinOut_q <= preFault;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wavePins[i] = (nrForce & nrEn_q[i]) ? nrVal_q[i]
                                          : pinOut_q[i];
    end
  end

  // read mux, registered at the setup phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      unique case ({paddr[11:2], 2'b00})
        `CTW_OFF_CTRL: prdata <= {23'h0, filtOn_q, cptEn_q, evCount_q,
                                  oneShot_q, dirDown_q, enable_q};
        `CTW_OFF_DBG:  prdata <= {31'h0, dbgRun_q};
        `CTW_OFF_STATUS: prdata <= {24'h0, chShV_q, pattShV_q, perShV_q,
                                    stopped_q, run};
        `CTW_OFF_FLAGS: prdata <= {24'h0, capFlag_q, 1'b0, rfFlag_q,
                                   nrFlag_q, ovfFlag_q};
        `CTW_OFF_COUNT: prdata <= {8'h0, count_q};
        `CTW_OFF_PER:   prdata <= {8'h0, per_q};
        `CTW_OFF_PERSH: prdata <= {8'h0, perSh_q};
        `CTW_OFF_PATTERN_VALUE:  prdata <= {16'h0, pattEn_q, pattVal_q};
        default: begin
          if (addr[11:4] == `CTW_OFF_CH >> 4) begin
            prdata <= {8'h0, ch_q[chIdx]};
          end
          if (addr[11:4] == `CTW_OFF_CHSH >> 4) begin
            prdata <= {8'h0, chSh_q[chIdx]};
          end
        end
      endcase
    end
  end

  property p_update_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
    (update && !dirDown_q && !(wr && addr == `CTW_OFF_COUNT) && !rfRestart
     && !retrigEv) |=> count_q == '0;
  endproperty
  a_update_wrap: assert property (p_update_wrap)
    else $error("no wrap");
  property p_debug_halt;
    @(posedge sys_clk) disable iff (!rst_n)
    (cpuHalted && !dbgRun_q) |-> !tick;
  endproperty
  a_debug_halt: assert property (p_debug_halt)
    else $error("ran in halt");
  property p_shadow_flag;
    @(posedge sys_clk) disable iff (!rst_n)
    (wr && addr == `CTW_OFF_PERSH) |=> perShV_q;
  endproperty
  a_shadow_flag: assert property (p_shadow_flag)
    else $error("no flag");
  property p_guard_free;
    @(posedge sys_clk) disable iff (!rst_n)
    (wrEn && addr == `CTW_OFF_PER) |=> per_q == $past(pwdata[CW-1:0]);
  endproperty
  a_guard_free: assert property (p_guard_free)
    else $error("period blocked");
  property p_debug_lift;
    @(posedge sys_clk) disable iff (!rst_n)
    cpuHalted |-> !guardBlock;
  endproperty
  a_debug_lift: assert property (p_debug_lift)
    else $error("guard in halt");
  property p_nr_force;
    @(posedge sys_clk) disable iff (!rst_n)
    (nrForce && nrEn_q[0]) |-> wavePins[0] == nrVal_q[0];
  endproperty
  a_nr_force: assert property (p_nr_force)
    else $error("no force");
  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    update |=> irqReq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no irq");
  property p_pattern_value;
    @(posedge sys_clk) disable iff (!rst_n)
    (!update && !(wr && addr == `CTW_OFF_PATTERN_VALUE)) |=> $stable(pattVal_q);
  endproperty
  a_pattern_value: assert property (p_pattern_value)
    else $error("pattern moved");
  c_update: cover property (@(posedge sys_clk) update);
  c_fault: cover property (@(posedge sys_clk) nrForce);
  c_capture: cover property (@(posedge sys_clk) |capFlag_q);
endmodule

// File: design/ctw_consts.svh
// constants for the control timer waveform core: offsets, fields, resets
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CTW_CONSTS_SVH
`define CTW_CONSTS_SVH
`define CTW_CNT_W        24
`define CTW_NCH          4
`define CTW_NOUT         8
`define CTW_OFF_CTRL     12'h000
`define CTW_OFF_GUARD    12'h004
`define CTW_OFF_DBG      12'h008
`define CTW_OFF_WAVE     12'h00c
`define CTW_OFF_DRV      12'h010
`define CTW_OFF_FLT      12'h014
`define CTW_OFF_STATUS   12'h018
`define CTW_OFF_FLAGS    12'h01c
`define CTW_OFF_COUNT    12'h020
`define CTW_OFF_PER      12'h024
`define CTW_OFF_PERSH    12'h028
`define CTW_OFF_PATTERN_VALUE     12'h02c
`define CTW_OFF_PATTSH   12'h030
`define CTW_OFF_CH       12'h040
`define CTW_OFF_CHSH     12'h050
`define CTW_PER_RST      24'hffffff
`define CTW_DT_RST       8'h00
`define CTW_FILT_LEN     3'h3
`endif

// File: design/ctw_pkg.sv
// types shared by the control timer waveform core
// assumes ctw_consts.svh is included by the users of the numbers
package ctw_pkg;
  typedef enum logic [2:0] {
    CTW_WG_NFRQ = 3'h0,
    CTW_WG_MFRQ = 3'h1,
    CTW_WG_NPWM = 3'h2,
    CTW_WG_MPWM = 3'h3
  } ctw_wavegen_t;
  typedef enum logic [1:0] {
    CTW_RF_OFF     = 2'h0,
    CTW_RF_RESTART = 2'h1,
    CTW_RF_HALT    = 2'h2,
    CTW_RF_MASK    = 2'h3
  } ctw_rfault_t;
endpackage

// File: design/ctw_dead_time.sv
// one dead-time pair: splits a waveform into low and high side drives
// assumes a single clock and a one-cycle tick per dead-time count
`include "ctw_consts.svh"
module ctw_dead_time
  import ctw_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       wave,
  input  wire logic [7:0] deadLs,
  input  wire logic [7:0] deadHs,
  output logic            lowSide,
  output logic            highSide
);
  logic [7:0] dtCnt_q;
  logic       wave_q;

  // both sides go low, then the new side waits out its dead time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q   <= 1'b0;
      dtCnt_q  <= 8'h00;
      lowSide  <= 1'b0;
      highSide <= 1'b0;
    end else if (!enable) begin
      wave_q   <= wave;
      dtCnt_q  <= 8'h00;
      lowSide  <= wave;
      highSide <= ~wave;
    end else if (wave != wave_q) begin
      wave_q   <= wave;
      dtCnt_q  <= wave ? deadLs : deadHs;
      lowSide  <= 1'b0;
      highSide <= 1'b0;
    end else if (dtCnt_q != 8'h00) begin
      dtCnt_q <= dtCnt_q - 8'h01;
    end else begin
      lowSide  <= wave_q;
      highSide <= ~wave_q;
    end
  end

  property p_no_overlap;
    @(posedge sys_clk) disable iff (!rst_n)
    enable |-> !(lowSide && highSide);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("dead-time overlap");
endmodule

// File: dv/ctw_switch_model.sv
// partner: power switch drivers hanging on the waveform pins
// assumes pair k has low side on pin k and high side on pin k+4
module ctw_switch_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] wavePins,
  input  wire logic [3:0] armed,
  output int              overlapCnt,
  output int              lsEdges
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pinLast_q;

  // both switches of a leg on shorts the supply, so every overlap on an armed leg counts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overlapCnt <= 0;
      lsEdges    <= 0;
      pinLast_q  <= 1'b0;
    end else begin
      pinLast_q <= wavePins[0];
      if (armed[0] && (wavePins[0] !== pinLast_q)) begin
        lsEdges <= lsEdges + 1;
      end
      if (|(wavePins[3:0] & wavePins[7:4] & armed)) begin
        overlapCnt <= overlapCnt + 1;
      end
    end
  end
endmodule

// File: dv/tb_ctw_core.sv
// self-checking bench for the control timer waveform core
// assumes a zero-wait apb slave on a 125 MHz sys_clk
`include "ctw_consts.svh"
module tb_ctw_core;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [11:0] ad;
    logic [31:0] wd;
    logic [31:0] ex;
    logic        er;
  } ctw_row_t;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic        cpuHalted, debuggerAccess, guardEnable, err;
  logic        channelEventInA, channelEventInB;
  logic        counterEventInA, counterEventInB;
  logic        irqReq, dmaReq, overflowEvent;
  logic [3:0]  captureEventIn, armed;
  logic [7:0]  wavePins;
  int          error_cnt = 0;
  int          checked = 0;
  int          overlapCnt, lsEdges, n;
  // register rows: write, let the crossing settle, read back
  ctw_row_t rows[6] = '{
    '{`CTW_OFF_PER, 32'hffffffff, 32'h00ffffff, 1'b0},
    '{`CTW_OFF_PERSH, 32'hff000009, 32'h00000009, 1'b0},
    '{`CTW_OFF_CH, 32'h00000005, 32'h00000005, 1'b0},
    '{`CTW_OFF_CH + 12'h004, 32'hffabcdef, 32'h00abcdef, 1'b0},
    '{`CTW_OFF_CHSH + 12'h00c, 32'h00000456, 32'h00000456, 1'b0},
    '{12'h060, 32'h00000001, 32'h00000000, 1'b1}
  };
  // guard rows: halted, debugger, offset, refusal expected
  logic [14:0] gtab[5] = '{
    {2'b00, `CTW_OFF_CTRL, 1'b1},
    {2'b00, `CTW_OFF_WAVE, 1'b0},
    {2'b00, `CTW_OFF_FLAGS, 1'b0},
    {2'b10, `CTW_OFF_CTRL, 1'b0},
    {2'b01, `CTW_OFF_DBG, 1'b0}
  };

  ctw_core ctw_core_i (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpuHalted, .debuggerAccess,
    .guardEnable, .channelEventInA, .channelEventInB,
    .counterEventInA, .counterEventInB, .captureEventIn, .irqReq,
    .dmaReq, .overflowEvent, .wavePins
  );
  ctw_switch_model ctw_switch_model_i (
    .sys_clk, .rst_n, .wavePins, .armed, .overlapCnt, .lsEdges
  );

  // 8 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one apb transfer; held until pready is seen with penable high
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles between two update pulses; the watchdog bounds the waits
  task automatic gap(output int cyc);
    cyc = 0;
    do @(posedge sys_clk); while (overflowEvent !== 1'b1);
    do begin
      @(posedge sys_clk);
      cyc++;
    end while (overflowEvent !== 1'b1);
  endtask

  // hang guard: the sequence needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {cpuHalted, debuggerAccess, guardEnable} = '0;
    {channelEventInA, channelEventInB} = '0;
    {counterEventInA, counterEventInB, captureEventIn, armed} = '0;
    repeat (20) @(posedge sys_clk);
    chk("rstout", {irqReq, dmaReq, overflowEvent, wavePins, pready},
        32'h1);
    rst_n <= 1'b1;
    apb(1'b0, `CTW_OFF_PER, 32'h0);
    chk("perrst", rd, 32'h00ffffff);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].ad, rows[i].wd);
      chk("refused", {31'h0, err}, {31'h0, rows[i].er});
      if (!rows[i].er) begin
        repeat (8) @(posedge sys_clk);
        apb(1'b0, rows[i].ad, 32'h0);
        chk("readback", rd, rows[i].ex);
      end
    end
    guardEnable <= 1'b1;
    foreach (gtab[i]) begin
      {cpuHalted, debuggerAccess} <= gtab[i][14:13];
      apb(1'b1, gtab[i][12:1], 32'h0);
      chk("guard", {31'h0, err}, {31'h0, gtab[i][0]});
    end
    {cpuHalted, debuggerAccess, guardEnable} <= 3'b000;
    // up then down: both wrap after ceiling plus one ticks
    apb(1'b1, `CTW_OFF_PER, 32'h9);
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, `CTW_OFF_CTRL, {30'h0, d[0], 1'b1});
      gap(n);
      gap(n);
      chk("updgap", n, 32'd10);
      apb(1'b1, `CTW_OFF_CTRL, 32'h0);
    end
    apb(1'b1, `CTW_OFF_WAVE, 32'h1);
    apb(1'b1, `CTW_OFF_CTRL, 32'h1);
    gap(n);
    gap(n);
    chk("topch0", n, 32'd6);
    chk("reqs", {irqReq, dmaReq}, 32'h3);
    apb(1'b1, `CTW_OFF_CTRL, 32'h0);
    repeat (8) @(posedge sys_clk);
    apb(1'b1, `CTW_OFF_FLAGS, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk("reqclr", {irqReq, dmaReq}, 32'h0);
    // debug halt freezes the count unless the run bit is set
    apb(1'b1, `CTW_OFF_WAVE, 32'h0);
    apb(1'b1, `CTW_OFF_PER, 32'h00ffffff);
    apb(1'b1, `CTW_OFF_CTRL, 32'h1);
    cpuHalted <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, `CTW_OFF_DBG, {31'h0, r[0]});
      repeat (8) @(posedge sys_clk);
      apb(1'b0, `CTW_OFF_COUNT, 32'h0);
      a = rd;
      repeat (5) @(posedge sys_clk);
      apb(1'b0, `CTW_OFF_COUNT, 32'h0);
      chk("dbgrun", {31'h0, rd !== a}, {31'h0, r[0]});
    end
    cpuHalted <= 1'b0;
    apb(1'b1, `CTW_OFF_CTRL, 32'h0);
    apb(1'b1, `CTW_OFF_DBG, 32'h0);
    apb(1'b1, `CTW_OFF_COUNT, 32'h0);
    apb(1'b1, `CTW_OFF_PER, 32'h9);
    apb(1'b1, `CTW_OFF_CTRL, 32'h1);
    apb(1'b1, `CTW_OFF_PATTERN_VALUE, 32'h0000ff96);
    gap(n);
    gap(n);
    repeat (3) @(posedge sys_clk);
    chk("pattern", {24'h0, wavePins}, 32'h96);
    apb(1'b1, `CTW_OFF_PATTERN_VALUE, 32'h0);
    // pair 0 split with two ticks of dead time on each edge
    apb(1'b1, `CTW_OFF_WAVE, 32'h02021002);
    armed <= 4'h1;
    repeat (100) @(posedge sys_clk);
    armed <= 4'h0;
    chk("overlap", overlapCnt, 32'h0);
    chk("lsmoves", {31'h0, lsEdges > 4}, 32'h1);
    apb(1'b1, `CTW_OFF_CTRL, 32'h0);
    // swapped pair 0 with the count parked below the channel 0 value
    apb(1'b1, `CTW_OFF_COUNT, 32'h0);
    apb(1'b1, `CTW_OFF_WAVE, 32'h00000100);
    repeat (4) @(posedge sys_clk);
    chk("swap", {30'h0, wavePins[4], wavePins[0]}, 32'h2);
    apb(1'b1, `CTW_OFF_CTRL, 32'h11);
    captureEventIn <= 4'h1;
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `CTW_OFF_FLAGS, 32'h0);
    chk("capflag", {31'h0, rd[4]}, 32'h1);
    // the fault must reach the pins before any clock edge does
    apb(1'b1, `CTW_OFF_DRV, 32'h000069ff);
    repeat (8) @(posedge sys_clk);
    counterEventInA <= 1'b1;
    #1;
    chk("nrforce", {24'h0, wavePins}, 32'h69);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, `CTW_OFF_FLAGS, 32'h0);
    chk("nrflag", {31'h0, rd[1]}, 32'h1);
    close_out();
  end
endmodule
